// >>> hdl/qrp_pkg.sv
// Shared constants and types for the queue read port and serial offset access.
// Assumes a single 125 MHz system clock; all device pins arrive asynchronously.
package qrp_pkg;

   // ****************************************************************
   // Widths and timing.
   // ****************************************************************
   localparam int WORD_W = 40;
   localparam int OFS_W = 16;
   localparam int NQ = 4;
   localparam int CHAIN_W = 2 * NQ * OFS_W;
   localparam int CLK_MHZ = 125;
   // Reset recovery before the mode pin becomes the serial input (least time, rounded up).
   localparam int RSR_NS = 20;
   localparam int RSR_CYC = (RSR_NS * CLK_MHZ + 999) / 1000;
   // Quiet time after leaving power down (least time, rounded up).
   localparam int WAKE_NS = 1000;
   localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
   // Rising read clock edge that moves a first word into the output register.
   localparam logic [1:0] FT_EDGE_LAST = 2'h2;
   localparam logic [OFS_W-1:0] OFS_RST = 16'h0080;

   // ****************************************************************
   // Register map.
   // ****************************************************************
   localparam logic [31:0] A_CTRL = 32'h0000_0000;
   localparam logic [31:0] A_STATUS = 32'h0000_0004;
   localparam logic [31:0] A_OFS0 = 32'h0000_0008;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0001;
   localparam int CTRL_HOLD = 0;
   localparam int ST_EMPTY_N = 0;
   localparam int ST_HAVE = 1;
   localparam int ST_FT = 2;
   localparam int ST_DDR = 3;
   localparam int ST_ASLEEP = 4;
   localparam int ST_WAKING = 5;
   localparam int ST_BUS_ON = 6;
   localparam int ST_CFG_RDY = 7;

   // ****************************************************************
   // Types.
   // ****************************************************************
   typedef struct packed {
      logic read_clock;
      logic read_enable_n;
      logic read_select_n;
      logic out_drive_en_n;
      logic read_dual_edge_sel;
      logic sleep_n;
      logic master_rst_n;
      logic partial_rst_n;
      logic fallthru_or_cfg_in;
      logic cfg_shift_clock;
      logic cfg_load_en_n;
      logic cfg_dump_en_n;
   } qrp_pins_t;
   localparam logic [11:0] PIN_IDLE = 12'h753;

   typedef enum logic [2:0] {
      MODE_RESET = 3'b001,
      MODE_RUN = 3'b010,
      MODE_SLEEP = 3'b100
   } qrp_mode_t;

endpackage

// >>> hdl/qrp_read_port.sv
// Read port control, power down and serial offset port of a four-queue buffer.
// Assumes queue storage on CLK offers its head word on WORD_IN/WORD_VALID and pops on WORD_TAKE.
//
// Summary of operation
// (R01) Select held low: output bus drives from the next rising read clock.
// (R02) Select high: next rising read clock floats the bus and starts no read.
// (R03) During master or partial reset only the output enable controls float.
// (R04) After reset outputs stay driven until the first rising read clock edge.
// (R05) Empty flag updates on read clock whatever the select does.
// (R06) Fall-through: first word reaches output register on third rising read clock.
// (R07) Reader asserts select on the next edge to see a fallen-through word.
// (R08) Dual edge strap: read on both edges, enables sampled on rising only.
// (R09) Single edge: read on rising edge with enable and select both low.
// (R10) The dual edge strap is held fixed by the outside party.
// (R11) Output enable low drives the output register, high floats the bus.
// (R12) Enables stay idle four clock cycles before sleep is asserted.
// (R13) Sleep is asynchronous, active low, held for the whole power down.
// (R14) While asleep all state is kept and inputs are ignored.
// (R15) While asleep data and serial outputs float.
// (R16) After wake wait one microsecond; continue without reset.
// (R17) Clocks should be held low while asleep; running ones are ignored.
// (R18) Load enable low shifts one serial bit per rising shift clock.
// (R19) Shift clock runs no faster than ten megahertz.
// (R20) Dump enable low presents one offset bit per rising shift clock.
// (R21) Each falling dump enable copies all offsets into the scan register.
// (R22) Dump enable is held low for the whole readout.
// (R23) After reset recovery the mode pin becomes the serial data input.
// (R24) One chain holds all eight offsets, same bit order in and out.
`timescale 1ns/100ps
module qrp_read_port (
   // Clock and reset.
   input wire logic CLK,
   input wire logic ARST_N,
   // Device pins, asynchronous to CLK.
   input wire qrp_pkg::qrp_pins_t PINS,
   // Queue head word from storage logic on CLK.
   input wire logic [qrp_pkg::WORD_W-1:0] WORD_IN,
   input wire logic WORD_VALID,
   output logic WORD_TAKE,
   // Data output bus, enable low while driving, and flag.
   output logic [qrp_pkg::WORD_W-1:0] DATA_OUT,
   output logic DATA_OE_N,
   output logic EMPTY_FLAG_N,
   // Serial readout pin, enable low while driving.
   output logic CFG_SERIAL_OUT,
   output logic CFG_SO_OE_N,
   // AHB-Lite slave.
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP
);
   import qrp_pkg::*;

   // ****************************************************************
   // Pin synchronisers and edge detection.
   // ****************************************************************
   localparam int NP = $bits(qrp_pins_t);
   logic [NP-1:0] meta_q, sync_q, prev_q;
   qrp_pins_t pin, pin_prev;
   logic rck_rise, rck_fall, sck_rise, dump_fall, in_reset;

   // Every pin passes two flops; the third only feeds edge detection.
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_sync
         always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
               meta_q[gi] <= PIN_IDLE[gi];
               sync_q[gi] <= PIN_IDLE[gi];
               prev_q[gi] <= PIN_IDLE[gi];
            end else begin
               meta_q[gi] <= PINS[gi];
               sync_q[gi] <= meta_q[gi];
               prev_q[gi] <= sync_q[gi];
            end
         end
      end
   endgenerate

   // Edges are found on the synchronised copies; the 80 ns link clock gives several cycles per phase.
   assign pin = qrp_pins_t'(sync_q);
   assign pin_prev = qrp_pins_t'(prev_q);
   assign rck_rise = pin.read_clock & ~pin_prev.read_clock;
   assign rck_fall = ~pin.read_clock & pin_prev.read_clock;
   assign sck_rise = pin.cfg_shift_clock & ~pin_prev.cfg_shift_clock;
   assign dump_fall = ~pin.cfg_dump_en_n & pin_prev.cfg_dump_en_n;
   assign in_reset = ~pin.master_rst_n | ~pin.partial_rst_n;

   // ****************************************************************
   // Mode control: reset, run and power down.
   // ****************************************************************
   qrp_mode_t mode_q, mode_d;
   logic ft_q, ft_d, ddr_q, ddr_d;
   logic [7:0] rsr_q, rsr_d, wake_q, wake_d;

   // Straps follow the pins while master reset is low and freeze at its release.
   always_comb begin
      mode_d = mode_q;
      ft_d = ft_q;
      ddr_d = ddr_q;
      rsr_d = rsr_q;
      wake_d = wake_q;
      unique case (mode_q)
         MODE_RESET: begin
            if (!pin.master_rst_n) begin
               ft_d = pin.fallthru_or_cfg_in;
               ddr_d = pin.read_dual_edge_sel; // [R08] [R09]
               rsr_d = 8'(RSR_CYC);
            end
            if (!pin.sleep_n) begin
               mode_d = MODE_SLEEP; // [R13]
            end else if (!in_reset) begin
               mode_d = MODE_RUN;
            end
         end
         MODE_RUN: begin
            if (!pin.sleep_n) begin
               mode_d = MODE_SLEEP; // [R13]
            end else if (in_reset) begin
               mode_d = MODE_RESET;
            end
         end
         MODE_SLEEP: begin
            if (pin.sleep_n) begin
               mode_d = MODE_RUN;
               wake_d = 8'(WAKE_CYC); // [R16]
            end
         end
         default: mode_d = MODE_RESET;
      endcase
      // Recovery and wake counters stand still while asleep, like all other state.
      if (mode_q != MODE_SLEEP && pin.master_rst_n && rsr_q != 8'h00) begin
         rsr_d = rsr_q - 8'h01; // [R23]
      end
      if (mode_q == MODE_RUN && wake_q != 8'h00) begin
         wake_d = wake_q - 8'h01; // [R16]
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mode_q <= MODE_RESET;
         ft_q <= 1'b0;
         ddr_q <= 1'b0;
         rsr_q <= 8'h00;
         wake_q <= 8'h00;
      end else begin
         mode_q <= mode_d;
         ft_q <= ft_d;
         ddr_q <= ddr_d;
         rsr_q <= rsr_d;
         wake_q <= wake_d;
      end
   end

   // ****************************************************************
   // Read path, output register and flag.
   // ****************************************************************
   logic [WORD_W-1:0] out_q, out_d;
   logic have_q, have_d, armed_q, armed_d, bus_on_q, bus_on_d;
   logic empty_n_q, empty_n_d, take_q, take_d, oe_n_q, oe_n_d;
   logic [1:0] ft_cnt_q, ft_cnt_d;
   logic [31:0] ctrl_q, ctrl_d;
   logic rd_ok, rd;

   // Reads are held off during the wake wait and while software asks to hold.
   assign rd_ok = (mode_q == MODE_RUN) && (wake_q == 8'h00) && !ctrl_q[CTRL_HOLD];
   assign rd = rd_ok & ~pin.read_enable_n & ~pin.read_select_n; // [R02] [R09]

   always_comb begin
      out_d = out_q;
      have_d = have_q;
      armed_d = armed_q;
      bus_on_d = bus_on_q;
      empty_n_d = empty_n_q;
      ft_cnt_d = ft_cnt_q;
      take_d = 1'b0;
      if (mode_q == MODE_RESET) begin
         bus_on_d = 1'b1; // [R03] [R04]
         have_d = 1'b0;
         armed_d = 1'b0;
         ft_cnt_d = 2'h0;
         empty_n_d = ft_q;
      end else if (mode_q == MODE_RUN && rck_rise) begin
         bus_on_d = ~pin.read_select_n; // [R01] [R02] [R04]
         armed_d = ddr_q & rd & WORD_VALID; // [R08]
         if (ft_q) begin
            if (have_q) begin
               if (rd) begin
                  have_d = WORD_VALID;
                  if (WORD_VALID) begin
                     out_d = WORD_IN;
                     take_d = 1'b1;
                  end
               end
            end else if (!WORD_VALID) begin
               ft_cnt_d = 2'h0;
            end else if (ft_cnt_q == FT_EDGE_LAST) begin
               out_d = WORD_IN; // [R06]
               take_d = 1'b1;
               have_d = 1'b1;
               ft_cnt_d = 2'h0;
            end else begin
               ft_cnt_d = ft_cnt_q + 2'h1; // [R06]
            end
            empty_n_d = ~have_d; // [R05]
         end else begin
            if (rd && WORD_VALID) begin
               out_d = WORD_IN; // [R09]
               take_d = 1'b1;
            end
            empty_n_d = WORD_VALID; // [R05]
         end
      end else if (mode_q == MODE_RUN && rck_fall && armed_q) begin
         // The falling-edge word is read without looking at enable or select.
         armed_d = 1'b0;
         if (WORD_VALID) begin
            out_d = WORD_IN; // [R08]
            take_d = 1'b1;
         end else if (ft_q) begin
            have_d = 1'b0;
         end
      end
      // Sleep floats the bus; otherwise enable and select decide.
      oe_n_d = pin.out_drive_en_n | ~bus_on_d | (mode_q == MODE_SLEEP); // [R03] [R11] [R15]
   end

   // Only the bus enable changes while asleep, since no edge is acted on outside reset or run.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         out_q <= '0;
         have_q <= 1'b0;
         armed_q <= 1'b0;
         bus_on_q <= 1'b1;
         empty_n_q <= 1'b0;
         ft_cnt_q <= 2'h0;
         take_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         out_q <= out_d; // [R14]
         have_q <= have_d;
         armed_q <= armed_d;
         bus_on_q <= bus_on_d;
         empty_n_q <= empty_n_d;
         ft_cnt_q <= ft_cnt_d;
         take_q <= take_d;
         oe_n_q <= oe_n_d;
      end
   end

   // ****************************************************************
   // Serial offset chain and scan-out register.
   // ****************************************************************
   logic [CHAIN_W-1:0] chain_q, chain_d, scan_q, scan_d;
   logic so_q, so_d, so_oe_n_q, so_oe_n_d;
   logic ser_on;

   assign ser_on = (mode_q != MODE_SLEEP); // [R14]

   // Bits enter at the bottom and leave from the top, so load and readout share one order.
   always_comb begin
      chain_d = chain_q;
      scan_d = scan_q;
      so_d = so_q;
      if (ser_on && sck_rise && !pin.cfg_load_en_n && rsr_q == 8'h00) begin
         chain_d = {chain_q[CHAIN_W-2:0], pin.fallthru_or_cfg_in}; // [R18] [R23] [R24]
      end
      if (ser_on && dump_fall) begin
         scan_d = chain_q; // [R21]
      end else if (ser_on && sck_rise && !pin.cfg_dump_en_n) begin
         so_d = scan_q[CHAIN_W-1]; // [R20] [R24]
         scan_d = {scan_q[CHAIN_W-2:0], 1'b0};
      end
      so_oe_n_d = ~ser_on; // [R15]
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         chain_q <= {(2 * NQ){OFS_RST}};
         scan_q <= '0;
         so_q <= 1'b0;
         so_oe_n_q <= 1'b1;
      end else begin
         chain_q <= chain_d;
         scan_q <= scan_d;
         so_q <= so_d;
         so_oe_n_q <= so_oe_n_d;
      end
   end

   // ****************************************************************
   // AHB-Lite register slave, zero wait states, always OKAY.
   // ****************************************************************
   logic wr_q, wr_d;
   logic [31:0] wadr_q, wadr_d, rdata_q, rdata_d, status;
   logic ap;

   assign ap = HSEL & HTRANS[1] & HREADY;
   assign status = {24'h00_0000, rsr_q == 8'h00, bus_on_q, wake_q != 8'h00, mode_q == MODE_SLEEP,
                    ddr_q, ft_q, have_q, empty_n_q};

   // Read data is chosen in the address phase and stands through the data phase.
   always_comb begin
      wr_d = ap & HWRITE;
      wadr_d = HADDR;
      ctrl_d = ctrl_q;
      rdata_d = rdata_q;
      if (ap && !HWRITE) begin
         rdata_d = 32'h0000_0000;
         if (HADDR == A_CTRL) begin
            rdata_d = ctrl_q;
         end
         if (HADDR == A_STATUS) begin
            rdata_d = status;
         end
         for (int i = 0; i < NQ; i++) begin
            if (HADDR == 32'(A_OFS0 + 32'(4 * i))) begin
               rdata_d = {chain_q[(2 * i + 1) * OFS_W +: OFS_W], chain_q[2 * i * OFS_W +: OFS_W]};
            end
         end
      end
      if (wr_q && wadr_q == A_CTRL) begin
         ctrl_d = HWDATA & CTRL_MASK;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wr_q <= 1'b0;
         wadr_q <= 32'h0000_0000;
         rdata_q <= 32'h0000_0000;
         ctrl_q <= CTRL_RST;
      end else begin
         wr_q <= wr_d;
         wadr_q <= wadr_d;
         rdata_q <= rdata_d;
         ctrl_q <= ctrl_d;
      end
   end

   // ****************************************************************
   // Outputs, each straight from a flop except the constant HREADYOUT and HRESP.
   // ****************************************************************
   assign WORD_TAKE = take_q;
   assign DATA_OUT = out_q;
   assign DATA_OE_N = oe_n_q;
   assign EMPTY_FLAG_N = empty_n_q;
   assign CFG_SERIAL_OUT = so_q;
   assign CFG_SO_OE_N = so_oe_n_q;
   assign HRDATA = rdata_q;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

endmodule

// >>> bench/qrp_props.sv
// Checker for the queue read port, watching the top module's ports only.
// Assumes every pin passes two or three flops before it acts.
`timescale 1ns/100ps
module qrp_props (
   // Clock and reset.
   input wire logic CLK,
   input wire logic ARST_N,
   // Pins and queue head.
   input wire qrp_pkg::qrp_pins_t PINS,
   input wire logic [qrp_pkg::WORD_W-1:0] WORD_IN,
   input wire logic WORD_VALID,
   input wire logic WORD_TAKE,
   // Outputs.
   input wire logic [qrp_pkg::WORD_W-1:0] DATA_OUT,
   input wire logic DATA_OE_N,
   input wire logic EMPTY_FLAG_N,
   input wire logic CFG_SERIAL_OUT,
   input wire logic CFG_SO_OE_N
);
   import qrp_pkg::*;
   // ****
   // Properties; repeat counts leave room for the pin synchronisers.
   // ****
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);
   a_take_one_cycle: assert property (WORD_TAKE |=> !WORD_TAKE)
      else $error("take lasted more than one cycle");
   a_take_loads_word: assert property (WORD_TAKE |-> DATA_OUT == $past(WORD_IN) && $past(WORD_VALID))
      else $error("taken word not in output register");
   a_reset_oe_only: assert property ((!PINS.master_rst_n && PINS.sleep_n && $stable(PINS.out_drive_en_n)) [*6]
      |-> DATA_OE_N == PINS.out_drive_en_n)
      else $error("bus enable not set by output enable in reset");
   a_reset_no_read: assert property ((!PINS.master_rst_n) [*4] |-> !WORD_TAKE)
      else $error("read during reset");
   a_sleep_floats: assert property ((!PINS.sleep_n) [*5] |-> DATA_OE_N && CFG_SO_OE_N)
      else $error("outputs driven while asleep");
   a_sleep_no_read: assert property ((!PINS.sleep_n) [*4] |-> !WORD_TAKE)
      else $error("read while asleep");
   a_sleep_holds_state: assert property ((!PINS.sleep_n) [*5]
      |-> $stable(DATA_OUT) && $stable(EMPTY_FLAG_N) && $stable(CFG_SERIAL_OUT))
      else $error("state changed while asleep");
   a_awake_cfg_drives: assert property (PINS.sleep_n [*6] |-> !CFG_SO_OE_N)
      else $error("serial output floats while awake");
   a_dump_idle_hold: assert property (PINS.cfg_dump_en_n [*6] |-> $stable(CFG_SERIAL_OUT))
      else $error("serial output moved without dump");
endmodule
bind qrp_read_port qrp_props i_qrp_props (.CLK(CLK), .ARST_N(ARST_N), .PINS(PINS), .WORD_IN(WORD_IN),
   .WORD_VALID(WORD_VALID), .WORD_TAKE(WORD_TAKE), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
   .EMPTY_FLAG_N(EMPTY_FLAG_N), .CFG_SERIAL_OUT(CFG_SERIAL_OUT), .CFG_SO_OE_N(CFG_SO_OE_N));

// >>> bench/qrp_host_mdl.sv
// Host side model: queue storage feeding the read port and the read clock.
// Assumes the bench pushes words into q and raises RUN to frame the clock.
`timescale 1ns/100ps
module qrp_host_mdl (
   // System clock.
   input wire logic CLK,
   // Read clock framing.
   input wire logic RUN,
   output logic RCLK,
   // Head word.
   input wire logic WORD_TAKE,
   output logic [qrp_pkg::WORD_W-1:0] WORD_IN,
   output logic WORD_VALID
);
   import qrp_pkg::*;
   logic [WORD_W-1:0] q[$];
   // ****
   // Behaviour
   // ****
   // The clock parks low between frames, so no stray edge is seen.
   initial begin
      RCLK = 1'b0;
      #3.3;
      forever begin
         #40;
         if (RUN || RCLK) RCLK = ~RCLK;
      end
   end
   // Pop on a take; an empty queue shows the inverse so stale data never matches.
   always @(posedge CLK) begin
      if (WORD_TAKE === 1'b1 && q.size() > 0) void'(q.pop_front());
      WORD_VALID <= q.size() > 0;
      WORD_IN <= (q.size() > 0) ? q[0] : ~WORD_IN;
   end
endmodule

// >>> bench/tb.sv
// Self-checking bench of the read port, power down, serial offsets and registers.
// Assumes the host model supplies the queue words and the read clock.
`timescale 1ns/100ps
module tb;
   import qrp_pkg::*;
   // ****
   // Wiring
   // ****
   logic clk = 1'b0, arst_n = 1'b0, run = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0, look_s = 1'b0;
   logic rclk, take, valid, oe_n, ef_n, so, so_oe_n, hrdy, hresp;
   logic [WORD_W-1:0] win, dout, last_w;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0] htrans = '0;
   logic [127:0] bits, chain;
   qrp_pins_t drv = PIN_IDLE, pins;
   logic [WORD_W-1:0] exp_w[$], exp_r[$], exp_s[$];
   int err_total = 0, samples_checked = 0, rises = 0, take_at = 0, r_base = 0;
   always #4 clk = ~clk;
   always @(posedge rclk) rises++;
   // The read clock comes from the host model, the rest from the driver.
   always_comb begin
      pins = drv;
      pins.read_clock = rclk;
   end
   qrp_read_port i_qrp_read_port (.CLK(clk), .ARST_N(arst_n), .PINS(pins), .WORD_IN(win), .WORD_VALID(valid),
      .WORD_TAKE(take), .DATA_OUT(dout), .DATA_OE_N(oe_n), .EMPTY_FLAG_N(ef_n), .CFG_SERIAL_OUT(so),
      .CFG_SO_OE_N(so_oe_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
      .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp));
   qrp_host_mdl i_qrp_host_mdl (.CLK(clk), .RUN(run), .RCLK(rclk), .WORD_TAKE(take), .WORD_IN(win),
      .WORD_VALID(valid));
   // ****
   // Checking
   // ****
   task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Each result takes the oldest note; a result with no note meets an unknown and fails.
   always @(posedge clk) begin
      if (take === 1'b1) begin
         take_at = rises;
         chk(dout, exp_w.size() ? exp_w.pop_front() : 'x);
      end
      if (rd_ph) begin
         chk(hrdata, exp_r.size() ? exp_r.pop_front() : 'x);
         chk(hresp, 1'b0);
      end
      if (look_s) chk(so, exp_s.size() ? exp_s.pop_front() : 'x);
      rd_ph = hsel && htrans[1] && !hwrite && hrdy;
   end
   // ****
   // Drivers
   // ****
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic done(input string s);
      cyc(2);
      chk(40'(exp_w.size() + exp_r.size() + exp_s.size()), '0);
      $display("test %s finished", s);
   endtask
   task automatic rdy_wait();
      int n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hrdy !== 1'b1 && n < 50);
      if (hrdy !== 1'b1) begin
         err_total++;
         complete_run();
      end
   endtask
   task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      rdy_wait();
      htrans <= 2'h0;
      hwdata <= d;
      rdy_wait();
   endtask
   task automatic rd(input logic [31:0] a, input logic [WORD_W-1:0] e);
      exp_r.push_back(e);
      ahb(a, 1'b0, '0);
   endtask
   task automatic en(input logic v);
      drv.read_enable_n <= v;
      drv.read_select_n <= v;
   endtask
   task automatic put(input logic note);
      last_w = {8'($urandom), $urandom};
      i_qrp_host_mdl.q.push_back(last_w);
      if (note) exp_w.push_back(last_w);
   endtask
   // Runs n rising read clock edges; off lifts the enables before the falling edge.
   task automatic rpulse(input int n, input logic off);
      int r0 = rises;
      run <= 1'b1;
      for (int i = 0; i < 400 && rises < r0 + n; i++) @(posedge clk);
      if (rises < r0 + n) begin
         err_total++;
         complete_run();
      end
      run <= 1'b0;
      if (off) begin
         cyc(2);
         en(1'b1);
      end
      cyc(12);
   endtask
   // One shift clock of 168 ns, well under the serial clock ceiling.
   task automatic sbit(input logic d, input logic look);
      drv.fallthru_or_cfg_in <= d;
      cyc(7);
      drv.cfg_shift_clock <= 1'b1;
      cyc(7);
      look_s <= look;
      cyc(1);
      look_s <= 1'b0;
      drv.cfg_shift_clock <= 1'b0;
      cyc(6);
   endtask
   task automatic dev_reset(input logic ft, input logic ddr);
      qrp_pins_t p = PIN_IDLE;
      p.fallthru_or_cfg_in = ft;
      p.read_dual_edge_sel = ddr;
      p.out_drive_en_n = 1'b0;
      run <= 1'b0;
      arst_n <= 1'b0;
      drv <= p;
      i_qrp_host_mdl.q.delete();
      cyc(16);
      arst_n <= 1'b1;
      cyc(8);
      chk(oe_n, 1'b0);
      p.master_rst_n = 1'b1;
      drv <= p;
      cyc(8);
   endtask
   // ****
   // Scenarios
   // ****
   initial begin
      void'($urandom(83));
      dev_reset(1'b0, 1'b0);
      rd(A_CTRL, CTRL_RST);
      rd(A_OFS0, {OFS_RST, OFS_RST});
      rd(32'h0000_0040, '0);
      ahb(A_CTRL, 1'b1, 32'hFFFF_FFFF);
      rd(A_CTRL, CTRL_MASK);
      ahb(A_CTRL, 1'b1, 32'h0000_0000);
      done("registers");
      put(1'b1);
      rpulse(1, 1'b0);
      chk(oe_n, 1'b1);
      chk(ef_n, 1'b1);
      en(1'b0);
      put(1'b1);
      put(1'b1);
      rpulse(3, 1'b0);
      chk(oe_n, 1'b0);
      rpulse(1, 1'b0);
      chk(ef_n, 1'b0);
      drv.read_select_n <= 1'b1;
      put(1'b0);
      rpulse(2, 1'b0);
      chk(oe_n, 1'b1);
      done("select");
      en(1'b1);
      rpulse(4, 1'b0);
      drv.sleep_n <= 1'b0;
      cyc(6);
      chk(oe_n, 1'b1);
      chk(so_oe_n, 1'b1);
      en(1'b0);
      rpulse(3, 1'b0);
      drv.sleep_n <= 1'b1;
      cyc(8);
      rpulse(1, 1'b0);
      cyc(WAKE_CYC);
      ahb(A_CTRL, 1'b1, 32'h0000_0001);
      rpulse(1, 1'b0);
      ahb(A_CTRL, 1'b1, 32'h0000_0000);
      exp_w.push_back(last_w);
      rpulse(1, 1'b0);
      done("sleep");
      drv.cfg_load_en_n <= 1'b0;
      for (int i = 0; i < 128; i++) begin
         bits[i] = 1'($urandom);
         sbit(bits[i], 1'b0);
      end
      drv.cfg_load_en_n <= 1'b1;
      repeat (3) sbit(1'b1, 1'b0);
      chain = {<<{bits}};
      for (int k = 0; k < 4; k++) rd(A_OFS0 + 32'(4 * k), chain[32 * k +: 32]);
      drv.cfg_dump_en_n <= 1'b0;
      cyc(8);
      for (int i = 0; i < 138; i++) begin
         if (i == 10) begin
            drv.cfg_dump_en_n <= 1'b1;
            cyc(8);
            drv.cfg_dump_en_n <= 1'b0;
            cyc(8);
         end
         exp_s.push_back(40'(bits[i < 10 ? i : i - 10]));
         sbit(1'b0, 1'b1);
      end
      drv.cfg_dump_en_n <= 1'b1;
      done("serial");
      dev_reset(1'b0, 1'b1);
      put(1'b1);
      put(1'b1);
      put(1'b0);
      en(1'b0);
      rpulse(1, 1'b1);
      done("dual edge");
      dev_reset(1'b1, 1'b0);
      put(1'b1);
      cyc(4);
      r_base = rises;
      rpulse(4, 1'b0);
      chk(40'(take_at - r_base), 40'h3);
      chk(oe_n, 1'b1);
      chk(ef_n, 1'b0);
      drv.read_select_n <= 1'b0;
      rpulse(1, 1'b0);
      chk(oe_n, 1'b0);
      chk(dout, last_w);
      done("fall through");
      complete_run();
   end
endmodule
